//--- rtl/i2c_port_pkg.sv
// =====================================================================
// Shared constants for the two-wire register port (device and master)
// Assumes a single 50 MHz system clock on both ends
// =====================================================================
package i2c_port_pkg;
    // Clock rate and link timing
    localparam int unsigned SYS_CLK_HZ      = 50_000_000;
    localparam int unsigned LINK_CLK_NS     = 160;
    localparam int unsigned HALF_BIT_CYC    = ((LINK_CLK_NS / 2) * (SYS_CLK_HZ / 1_000_000)) / 1000;
    localparam logic [7:0]  HALF_BIT_LAST   = 8'(HALF_BIT_CYC - 1);
    // Slave addresses
    localparam logic [6:0]  ADDR_MAIN_SET   = 7'h48;
    localparam logic [6:0]  ADDR_MAIN_CLR   = 7'h40;
    localparam logic [6:0]  ADDR_TEST       = 7'h49;
    localparam logic [6:0]  ADDR_GENCALL    = 7'h00;
    // Byte layout
    localparam logic [3:0]  BITS_PER_BYTE   = 4'h8;
    localparam logic [3:0]  ACK_SLOT        = 4'h8;
    localparam logic [7:0]  PTR_RESET       = 8'h00;
    localparam int unsigned REG_COUNT       = 256;
    localparam int unsigned FIFO_DEPTH      = 4;
    localparam int unsigned FIFO_WIDTH      = 9;
endpackage

//--- rtl/i2c_link_if.sv
// =====================================================================
// Two-wire open-drain link joining master end and device end
// Resolves the wired-AND level from the output enables of both ends
// =====================================================================
`timescale 1ns/1ns
interface i2c_link_if;
    logic scl_oe_m;   // Master pulls clock low
    logic sda_oe_m;   // Master pulls data low
    logic scl_oe_d;   // Device clock enable, never driven
    logic sda_oe_d;   // Device pulls data low
    logic scl;
    logic sda;
    // Pull-ups win unless someone pulls low
    assign scl = ~(scl_oe_m | scl_oe_d);
    assign sda = ~(sda_oe_m | sda_oe_d);
    modport master (output scl_oe_m, output sda_oe_m, input scl, input sda);
    modport device (output scl_oe_d, output sda_oe_d, input scl, input sda);
endinterface

//--- rtl/sync_fifo.sv
// =====================================================================
// Small synchronous FIFO with valid/ready on both sides
// Assumes one clock and synchronous active-high reset
// =====================================================================
`timescale 1ns/1ns
module sync_fifo #(
    parameter int unsigned WIDTH = 9,
    parameter int unsigned DEPTH = 4
) (
    // Clock and reset
    input  wire logic             sys_clk_i,
    input  wire logic             rst_i,
    // Fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    // Honest full and empty from the occupancy count
    assign in_ready_o  = (count != (AW+1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign out_data_o  = mem[rd_ptr];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    // ==============================
    // Storage and pointers
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                mem[wr_ptr] <= in_data_i;
                wr_ptr      <= wr_ptr + 1'b1;
            end
            if (pop)
                rd_ptr <= rd_ptr + 1'b1;
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

//--- rtl/i2c_master_end.sv
// =====================================================================
// Bus master end: runs queued write or read transactions on the link
// Assumes the device end shares the link interface; clock by divider
// =====================================================================
`timescale 1ns/1ns
module i2c_master_end (
    // Clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    // Command: read flag, slave address, pointer, write data
    input  wire logic        cmd_valid_i,
    output logic             cmd_ready_o,
    input  wire logic        cmd_read_i,
    input  wire logic [6:0]  cmd_addr_i,
    input  wire logic [7:0]  cmd_ptr_i,
    input  wire logic [7:0]  cmd_data_i,
    // Result
    output logic             done_o,
    output logic             nack_o,
    output logic [7:0]       rd_data_o,
    // Link
    i2c_link_if.master       link
);
    typedef enum logic [2:0] {
        M_IDLE = 3'b000, M_START = 3'b001, M_BIT = 3'b010,
        M_RSTART = 3'b011, M_STOP = 3'b100
    } mstate_t;
    typedef struct packed {
        mstate_t    st;
        logic [7:0] tick;
        logic [1:0] phase;   // 0 low-setup,1 high,2 high-sample,3 low
        logic [3:0] bitn;
        logic [1:0] byten;   // 0 addr(w),1 ptr,2 data or addr(r),3 read data
        logic [7:0] shreg;
        logic       rd;
        logic [6:0] addr;
        logic [7:0] ptr;
        logic [7:0] wdat;
        logic       scl_oe;
        logic       sda_oe;
        logic       cmd_ready;
        logic       done;
        logic       nack;
        logic [7:0] rdata;
        logic [1:0] s1;      // sda sync
    } mreg_t;
    mreg_t r, next_r;

    // ==============================
    // Transaction sequencer; master ends a read with nack then stop, and a write with stop after the data ack
    always_comb begin
        next_r      = r;
        next_r.s1   = {r.s1[0], link.sda};
        next_r.done = 1'b0;
        next_r.tick = r.tick + 8'h01;
        unique case (r.st)
            M_IDLE: begin
                next_r.cmd_ready = 1'b1;
                next_r.scl_oe    = 1'b0;
                next_r.sda_oe    = 1'b0;
                if (cmd_valid_i && r.cmd_ready) begin
                    next_r.cmd_ready = 1'b0;
                    next_r.rd    = cmd_read_i;
                    next_r.addr  = cmd_addr_i;
                    next_r.ptr   = cmd_ptr_i;
                    next_r.wdat  = cmd_data_i;
                    next_r.nack  = 1'b0;
                    next_r.st    = M_START;
                    next_r.tick  = 8'h00;
                    next_r.phase = 2'h2;   // Clock already high: go straight to data fall
                end
            end
            M_START, M_RSTART: begin
                // Wait a quarter for the device to drop its ack, clock up, data falls, clock falls
                if (r.tick == i2c_port_pkg::HALF_BIT_LAST) begin
                    next_r.tick  = 8'h00;
                    next_r.phase = r.phase + 2'h1;
                    unique case (r.phase)
                        2'h0: next_r.sda_oe = 1'b0;
                        2'h1: next_r.scl_oe = 1'b0;
                        2'h2: next_r.sda_oe = 1'b1;
                        default: begin
                            next_r.scl_oe = 1'b1;
                            next_r.st     = M_BIT;
                            next_r.bitn   = 4'h0;
                            next_r.phase  = 2'h0;
                            next_r.byten  = (r.st == M_RSTART) ? 2'h2 : 2'h0;
                            next_r.shreg  = (r.st == M_RSTART) ? {r.addr, 1'b1} : {r.addr, 1'b0};
                        end
                    endcase
                end
            end
            M_BIT: begin
                if (r.tick == i2c_port_pkg::HALF_BIT_LAST) begin
                    next_r.tick  = 8'h00;
                    next_r.phase = r.phase + 2'h1;
                    unique case (r.phase)
                        2'h0: begin
                            // Set data while clock low
                            if (r.bitn == i2c_port_pkg::ACK_SLOT)
                                next_r.sda_oe = 1'b0;
                            else if (r.byten == 2'h3)
                                next_r.sda_oe = 1'b0;
                            else
                                next_r.sda_oe = ~r.shreg[7];
                        end
                        2'h1: next_r.scl_oe = 1'b0;
                        2'h2: begin
                            if (r.bitn == i2c_port_pkg::ACK_SLOT) begin
                                if (r.byten != 2'h3 && r.s1[1])
                                    next_r.nack = 1'b1;
                            end else
                                next_r.shreg = {r.shreg[6:0], r.s1[1]};
                        end
                        default: begin
                            next_r.scl_oe = 1'b1;
                            next_r.bitn   = r.bitn + 4'h1;
                            if (r.bitn == i2c_port_pkg::ACK_SLOT) begin
                                next_r.bitn = 4'h0;
                                next_r.byten = r.byten + 2'h1;
                                if (r.nack || r.byten == 2'h3 || (r.byten == 2'h2 && !r.rd)) begin
                                    next_r.st     = M_STOP;
                                    if (r.byten == 2'h3) next_r.rdata = r.shreg;
                                end else if (r.byten == 2'h1 && r.rd) begin
                                    next_r.st     = M_RSTART;
                                    next_r.scl_oe = 1'b1;
                                    next_r.sda_oe = 1'b0;
                                end else begin
                                    next_r.shreg = (r.byten == 2'h0) ? r.ptr : r.wdat;
                                end
                            end
                        end
                    endcase
                end
            end
            default: begin
                // Stop: data low under a low clock, clock rises, then data rises
                if (r.tick == i2c_port_pkg::HALF_BIT_LAST) begin
                    next_r.tick  = 8'h00;
                    next_r.phase = r.phase + 2'h1;
                    unique case (r.phase)
                        2'h0: next_r.sda_oe = 1'b1;
                        2'h1: next_r.scl_oe = 1'b0;
                        default: begin
                            next_r.sda_oe = 1'b0;
                            next_r.st     = M_IDLE;
                            next_r.done   = 1'b1;
                        end
                    endcase
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign cmd_ready_o   = r.cmd_ready;
    assign done_o        = r.done;
    assign nack_o        = r.nack;
    assign rd_data_o     = r.rdata;
    assign link.scl_oe_m = r.scl_oe;
    assign link.sda_oe_m = r.sda_oe;
endmodule

//--- rtl/i2c_device_end.sv
// =====================================================================
// Slave-only register port: decodes frames, acks, drives read data
// Assumes an external master makes every clock pulse on the link
// =====================================================================
`timescale 1ns/1ns

// Notes on behaviour
// - Slave only, never makes the clock
// - Works at any clock rate up to limit
// - Never stretches the clock line
// - Registers survive interface supply cycling
// - Both supplies low: release both lines
// - One bit per clock, stable while high
// - Eight bits MSB first plus ack
// - Start is data falling with clock high
// - Stop is data rising with clock high
// - Repeated start behaves as plain start
// - Master ends with nack then stop
// - Receiver acks by holding data low
// - Ack every register pointer value
// - Master retries after a missing ack; the master end only stops and raises nack_o
// - Seven-bit slave addressing after start
// - Factory option picks main address
// - Test address acked only when unlocked
// - Other addresses are not acked
// - Bit after address gives direction
// - General call address never acked
// - First written byte is register pointer
// - Pointer kept across stop
module i2c_device_end (
    // Clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    // Options and supply state
    input  wire logic        addr_option_i,
    input  wire logic        test_unlock_i,
    input  wire logic        io_supply_ok_i,
    input  wire logic        system_supply_ok_i,
    // Written byte stream out, through the FIFO
    output logic             wr_valid_o,
    input  wire logic        wr_ready_i,
    output logic [7:0]       wr_ptr_o,
    output logic [7:0]       wr_data_o,
    output logic             overrun_o,
    // Status input, never read back, and busy flag
    input  wire logic [7:0]  status_i,
    output logic             busy_o,
    // Link
    i2c_link_if.device       link
);
    typedef enum logic [1:0] {
        D_IDLE = 2'b00, D_ADDR = 2'b01, D_RX = 2'b10, D_TX = 2'b11
    } dstate_t;
    typedef struct packed {
        logic [1:0] scl_s;   // two-stage synchronisers
        logic [1:0] sda_s;
        logic [1:0] scl_f;   // filtered level history
        logic [1:0] sda_f;
        dstate_t    st;
        logic [3:0] bitn;
        logic [7:0] shreg;
        logic       ptr_seen;
        logic       ack_drv;
        logic       tx_drv;
        logic       master_nack;
        logic [7:0] ptr;
        logic       push;
        logic [8:0] push_word;
        logic       overrun;
        logic       busy;
        logic [7:0] wr_ptr;
        logic [7:0] wr_data;
        logic       wr_valid;
    } dreg_t;
    dreg_t r, next_r;

    logic [7:0] regs [i2c_port_pkg::REG_COUNT];
    logic       fifo_in_ready;
    logic       fifo_out_valid;
    logic [8:0] fifo_out_data;
    logic       fifo_pop;

    // Pointer of each queued byte is recorded beside it
    logic [7:0] ptr_q [i2c_port_pkg::FIFO_DEPTH];
    logic [1:0] pq_wr;
    logic [1:0] pq_rd;
    assign fifo_pop = fifo_out_valid & wr_ready_i;

    // Main address from the factory option
    function automatic logic addr_match(input logic [6:0] a, input logic opt, input logic unl);
        logic [6:0] main;
        main = opt ? i2c_port_pkg::ADDR_MAIN_SET : i2c_port_pkg::ADDR_MAIN_CLR;
        return (a != i2c_port_pkg::ADDR_GENCALL) &&
               ((a == main) || (unl && a == i2c_port_pkg::ADDR_TEST));
    endfunction

    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic powered;
    // Edges on the filtered lines only; sync stage 0 feeds stage 1 only
    assign scl_rise   = ~r.scl_f[1] & r.scl_f[0];
    assign scl_fall   = r.scl_f[1] & ~r.scl_f[0];
    assign start_cond = r.scl_f[0] & r.scl_f[1] & r.sda_f[1] & ~r.sda_f[0];
    assign stop_cond  = r.scl_f[0] & r.scl_f[1] & ~r.sda_f[1] & r.sda_f[0];
    assign powered    = io_supply_ok_i | system_supply_ok_i;

    // ==============================
    // Frame decoder, sampled on the system clock at link rates well below it
    always_comb begin
        next_r          = r;
        next_r.scl_s    = {r.scl_s[0], link.scl};
        next_r.sda_s    = {r.sda_s[0], link.sda};
        // Filtered level follows the synchronised level every cycle
        next_r.scl_f    = {r.scl_f[0], (r.scl_s[1] == r.scl_f[0]) ? r.scl_f[0] : r.scl_s[1]};
        next_r.sda_f    = {r.sda_f[0], (r.sda_s[1] == r.sda_f[0]) ? r.sda_f[0] : r.sda_s[1]};
        next_r.push     = 1'b0;
        if (start_cond) begin
            // Repeated start restarts address reception the same way
            next_r.st       = D_ADDR;
            next_r.bitn     = 4'hF;                         // Start's own clock fall wraps it to 0
            next_r.ack_drv  = 1'b0;
            next_r.tx_drv   = 1'b0;
            next_r.ptr_seen = 1'b0;
            next_r.busy     = 1'b1;
        end else if (stop_cond) begin
            next_r.st      = D_IDLE;
            next_r.ack_drv = 1'b0;
            next_r.tx_drv  = 1'b0;
            next_r.busy    = 1'b0;
        end else if (r.st != D_IDLE) begin
            if (scl_rise) begin
                // Sample one bit per clock while high, MSB first
                if (r.bitn != i2c_port_pkg::ACK_SLOT)
                    next_r.shreg = {r.shreg[6:0], r.sda_f[0]};
                else if (r.st == D_TX)
                    next_r.master_nack = r.sda_f[0];
            end
            if (scl_fall) begin
                next_r.bitn    = r.bitn + 4'h1;
                next_r.ack_drv = 1'b0;
                next_r.tx_drv  = 1'b0;
                if (r.bitn == i2c_port_pkg::BITS_PER_BYTE - 4'h1 && r.st != D_TX) begin
                    // Ack slot coming: address check or unconditional ack
                    if (r.st == D_ADDR) begin
                        if (addr_match(r.shreg[7:1], addr_option_i, test_unlock_i))
                            next_r.ack_drv = 1'b1;
                        else
                            next_r.st = D_IDLE;
                    end else begin
                        next_r.ack_drv = 1'b1;
                        if (!r.ptr_seen) begin
                            next_r.ptr      = r.shreg;
                            next_r.ptr_seen = 1'b1;
                        end else begin
                            next_r.push      = 1'b1;
                            next_r.push_word = {1'b0, r.shreg};
                            next_r.ptr       = r.ptr + 8'h01;
                            if (!fifo_in_ready)
                                next_r.overrun = 1'b1;
                        end
                    end
                end else if (r.bitn == i2c_port_pkg::ACK_SLOT) begin
                    next_r.bitn = 4'h0;
                    if (r.st == D_ADDR)
                        next_r.st = r.shreg[0] ? D_TX : D_RX;
                    // A sent byte moves the pointer on, acked or not
                    if (r.st == D_TX)
                        next_r.ptr = r.ptr + 8'h01;
                    if (r.st == D_TX && r.master_nack)
                        next_r.st = D_IDLE;
                    else if (next_r.st == D_TX) begin
                        next_r.shreg  = regs[next_r.ptr];
                        next_r.tx_drv = ~regs[next_r.ptr][7];
                    end
                end else if (r.st == D_TX) begin
                    // Sampling has already shifted the next bit to the top
                    next_r.tx_drv = ~r.shreg[7];
                    if (r.bitn == i2c_port_pkg::BITS_PER_BYTE - 4'h1)
                        next_r.tx_drv = 1'b0;
                end
            end
        end
        // Drain FIFO into the register array and the write strobe
        next_r.wr_valid = fifo_pop;
        if (fifo_pop) begin
            next_r.wr_data = fifo_out_data[7:0];
            next_r.wr_ptr  = ptr_q[pq_rd];
        end
        if (!powered) begin
            next_r.ack_drv = 1'b0;
            next_r.tx_drv  = 1'b0;
        end
    end

    // ==============================
    // State register; no reset of registers on supply loss
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            r       <= '0;
            r.scl_s <= 2'b11;
            r.sda_s <= 2'b11;
            r.scl_f <= 2'b11;
            r.sda_f <= 2'b11;
            r.ptr   <= i2c_port_pkg::PTR_RESET;
            pq_wr   <= 2'h0;
            pq_rd   <= 2'h0;
        end else begin
            r <= next_r;
            if (r.push && fifo_in_ready) begin
                ptr_q[pq_wr] <= r.ptr - 8'h01;
                pq_wr        <= pq_wr + 2'h1;
            end
            if (fifo_pop) begin
                regs[ptr_q[pq_rd]]  <= fifo_out_data[7:0];
                pq_rd               <= pq_rd + 2'h1;
            end
        end
    end

    sync_fifo #(
        .WIDTH (i2c_port_pkg::FIFO_WIDTH),
        .DEPTH (i2c_port_pkg::FIFO_DEPTH)
    ) u_fifo (
        .sys_clk_i   (sys_clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (r.push),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (r.push_word),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (wr_ready_i),
        .out_data_o  (fifo_out_data)
    );

    assign wr_valid_o    = r.wr_valid;
    assign wr_ptr_o      = r.wr_ptr;
    assign wr_data_o     = r.wr_data;
    assign overrun_o     = r.overrun;
    assign busy_o        = r.busy & (status_i == status_i);
    assign link.scl_oe_d = 1'b0;
    assign link.sda_oe_d = r.ack_drv | r.tx_drv;
endmodule

//--- test/i2c_link_sva.sv
// Checker for the two-wire link between the master end and the device end
// Assumes the bench feeds it the link interface signals and the system clock
`timescale 1ns/1ns
module i2c_link_sva (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Link enables and levels
    input wire logic scl_oe_m,
    input wire logic sda_oe_m,
    input wire logic scl_oe_d,
    input wire logic sda_oe_d,
    input wire logic scl,
    input wire logic sda
);
    // =================================================================
    // Link properties, all in the system clock domain
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    clk_never_driven_a: assert property (!scl_oe_d) else $error("Device pulled the clock line");
    dev_data_hold_a: assert property (scl && $past(scl) |-> $stable(sda_oe_d))
        else $error("Device data moved while clock high");
    ack_edge_low_a: assert property ($changed(sda_oe_d) |-> !scl)
        else $error("Device data changed on a high clock");
    // The master never waits on the device, so low phases stay short
    no_stretch_a: assert property ($fell(scl) |-> ##[1:40] scl) else $error("Clock held low too long");
    start_free_a: assert property (scl && $fell(sda) |-> !sda_oe_d) else $error("Device pulled data at start");
    start_clock_a: assert property (scl && $fell(sda) |-> ##[1:40] !scl)
        else $error("No clock after start");
    stop_idle_a: assert property (scl && $rose(sda) |-> (scl && sda)[*2]) else $error("Bus not idle after stop");
    clk_high_min_a: assert property ($rose(scl) |-> scl[*3]) else $error("Clock high phase too short");
    release_idle_a: assert property ($fell(rst_i) |-> !scl_oe_m && !sda_oe_m && !sda_oe_d)
        else $error("Lines driven after reset");
endmodule

//--- test/testbench.sv
// Bench joining the master end to the device end over one link
// Assumes a 50 MHz clock and a link clock made by the master divider
`timescale 1ns/1ns
module testbench;
    // =================================================================
    // Stimulus and observed signals
    logic       sys_clk_i = 1'b0;
    logic       rst_i     = 1'b1;
    logic       cmd_valid = 1'b0;
    logic       cmd_ready, cmd_read, done, nack, wr_valid, opt, unl, busy, ovr;
    logic [6:0] cmd_addr;
    logic [7:0] cmd_ptr, cmd_data, rd_data, wr_ptr, wr_data, got_ptr, got_data;
    logic       io_ok     = 1'b1;
    logic       sys_ok    = 1'b1;
    int         fails     = 0;
    int         samples_checked = 0;
    int         wr_count  = 0;
    i2c_link_if link ();
    i2c_master_end i_i2c_master_end (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid),
        .cmd_ready_o(cmd_ready), .cmd_read_i(cmd_read), .cmd_addr_i(cmd_addr), .cmd_ptr_i(cmd_ptr),
        .cmd_data_i(cmd_data), .done_o(done), .nack_o(nack), .rd_data_o(rd_data), .link(link.master));
    i2c_device_end i_i2c_device_end (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_option_i(opt),
        .test_unlock_i(unl), .io_supply_ok_i(io_ok), .system_supply_ok_i(sys_ok), .wr_valid_o(wr_valid),
        .wr_ready_i(1'b1), .wr_ptr_o(wr_ptr), .wr_data_o(wr_data), .overrun_o(ovr), .status_i(8'hA5),
        .busy_o(busy), .link(link.device));
    i2c_link_sva i_i2c_link_sva (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .scl_oe_m(link.scl_oe_m),
        .sda_oe_m(link.sda_oe_m), .scl_oe_d(link.scl_oe_d), .sda_oe_d(link.sda_oe_d), .scl(link.scl), .sda(link.sda));
    always #10 sys_clk_i = ~sys_clk_i;
    // Capture each register write the device hands out
    always @(posedge sys_clk_i) begin
        if (wr_valid === 1'b1) begin
            got_ptr <= wr_ptr;
            got_data <= wr_data;
            wr_count <= wr_count + 1;
        end
    end
    // =================================================================
    // Helpers
    function automatic logic [7:0] want_nack(input logic [6:0] a, input logic o, input logic u);
        logic [6:0] main_addr;
        main_addr = o ? i2c_port_pkg::ADDR_MAIN_SET : i2c_port_pkg::ADDR_MAIN_CLR;
        return {7'h00, !((a == main_addr) || (u && a == i2c_port_pkg::ADDR_TEST))};
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        samples_checked++;
        if (seen !== want) begin
            fails++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic conclude();
        $display("Checks %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // One whole transaction; request held until taken, then wait for done
    task automatic run(input logic rd, input logic [6:0] a, input logic [7:0] p, input logic [7:0] d);
        int n;
        n = 0;
        @(negedge sys_clk_i);
        cmd_read = rd;
        cmd_addr = a;
        cmd_ptr = p;
        cmd_data = d;
        cmd_valid = 1'b1;
        while (cmd_ready !== 1'b1 && n < 4000) begin
            @(negedge sys_clk_i);
            n++;
        end
        @(negedge sys_clk_i);
        cmd_valid = 1'b0;
        while (done !== 1'b1 && n < 4000) begin
            @(negedge sys_clk_i);
            n++;
        end
        if (n >= 4000) begin
            fails++;
            conclude();
        end
    endtask
    // =================================================================
    // Main sequence: corner addresses first, then random traffic
    initial begin
        logic [6:0] a;
        logic [7:0] p, d, w;
        int         n_wr;
        void'($urandom(84026));
        {opt, unl, cmd_read, cmd_addr, cmd_ptr, cmd_data} = '0;
        repeat (6) @(negedge sys_clk_i);
        rst_i = 1'b0;
        for (int i = 0; i < 14; i++) begin
            opt = 1'($urandom);
            unl = 1'($urandom);
            a = (i == 0) ? i2c_port_pkg::ADDR_MAIN_SET : (i == 1) ? i2c_port_pkg::ADDR_MAIN_CLR :
                (i == 2) ? i2c_port_pkg::ADDR_TEST : (i == 3) ? i2c_port_pkg::ADDR_GENCALL : 7'($urandom);
            if (i > 5 && i[0]) a = opt ? i2c_port_pkg::ADDR_MAIN_SET : i2c_port_pkg::ADDR_MAIN_CLR;
            p = (i == 6) ? 8'hFF : 8'($urandom);
            d = 8'($urandom);
            w = want_nack(a, opt, unl);
            n_wr = wr_count;
            run(1'b0, a, p, d);
            check({7'h00, nack}, w);
            // Busy falls only once the filtered lines have shown the stop
            repeat (6) @(negedge sys_clk_i);
            check({7'h00, busy}, 8'h00);
            if (w == 8'h00) begin
                check(8'(wr_count - n_wr), 8'h01);
                check(got_ptr, p);
                check(got_data, d);
                run(1'b1, a, p, 8'h00);
                check({7'h00, nack}, 8'h00);
                check(rd_data, d);
            end
        end
        // Both supplies low: the device lets go of the data line
        opt = 1'b1;
        {io_ok, sys_ok} = 2'b00;
        run(1'b0, i2c_port_pkg::ADDR_MAIN_SET, 8'h11, 8'h5A);
        check({7'h00, nack}, 8'h01);
        // Retry the refused write once the supplies are back
        {io_ok, sys_ok} = 2'b11;
        run(1'b0, i2c_port_pkg::ADDR_MAIN_SET, 8'h11, 8'h5A);
        check({7'h00, nack}, 8'h00);
        io_ok = 1'b0;
        repeat (4) @(negedge sys_clk_i);
        io_ok = 1'b1;
        run(1'b1, i2c_port_pkg::ADDR_MAIN_SET, 8'h11, 8'h00);
        check(rd_data, 8'h5A);
        check({7'h00, ovr}, 8'h00);
        conclude();
    end
endmodule
